// >>> rta_defines.vh
// Register offsets, field positions and reset values for the timer.
`ifndef RTA_DEFINES_VH
`define RTA_DEFINES_VH

// =============================================================
// Register offsets
`define RTA_ADDR_IRQ_CTRL 4'h1
`define RTA_ADDR_ALM_MIN 4'h9
`define RTA_ADDR_ALM_HOUR 4'hA
`define RTA_ADDR_ALM_DAY 4'hB
`define RTA_ADDR_ALM_WDAY 4'hC
`define RTA_ADDR_TMR_CTRL 4'hE
`define RTA_ADDR_CD_RELOAD 4'hF

// =============================================================
// Serial command byte
`define RTA_CMD_READ_BIT 7
`define RTA_CMD_SUB_HI 6
`define RTA_CMD_SUB_LO 4
`define RTA_CMD_SUBADDR 3'h1

// =============================================================
// Interrupt control and status fields
`define RTA_IC_MINUTE_EN 7
`define RTA_IC_SECOND_EN 6
`define RTA_IC_TICK_FLAG 5
`define RTA_IC_PULSE_SEL 4
`define RTA_IC_ALARM_FLAG 3
`define RTA_IC_CD_FLAG 2
`define RTA_IC_ALARM_IE 1
`define RTA_IC_CD_IE 0

// =============================================================
// Timer control fields
`define RTA_TC_COF_HI 6
`define RTA_TC_COF_LO 4
`define RTA_TC_RUN 3
`define RTA_TC_SEL_HI 1
`define RTA_TC_SEL_LO 0

// =============================================================
// Countdown clock select codes
`define RTA_SEL_4096HZ 2'h0
`define RTA_SEL_64HZ 2'h1
`define RTA_SEL_1HZ 2'h2
`define RTA_SEL_1_60HZ 2'h3

// =============================================================
// Alarm field layout
`define RTA_ALM_DIS_BIT 7
`define RTA_ALM_MIN_MASK 8'h7F
`define RTA_ALM_HOUR_MASK 8'h3F
`define RTA_ALM_DAY_MASK 8'h3F
`define RTA_ALM_WDAY_MASK 8'h07

// =============================================================
// Reset values and timer control write mask
`define RTA_RST_ALARM 8'h80
`define RTA_RST_IRQ_CTRL 8'h00
`define RTA_RST_TMR_CTRL 8'h03
`define RTA_RST_RELOAD 8'h00
`define RTA_TMR_CTRL_MASK 8'h7B

`endif

// >>> rta_timer.v
// Alarm, periodic tick and countdown timer with serial register access.
`include "rta_defines.vh"

// Function
// - A clear top bit of an alarm register enables that field's comparison.
// - Alarm flag sets when all enabled minute/hour/day/weekday fields first match.
// - The alarm flag stays set until the host clears it.
// - After clearing, alarm sets again only on a fresh entry into match.
// - An alarm field with its top bit set never blocks or causes a match.
// - With alarm interrupt enabled, the interrupt follows the alarm flag level.
// - Writing the status register ANDs each flag with the written bit.
// - Tick flag is bit 5, alarm flag bit 3, countdown flag bit 2.
// - Select 00=4096 Hz, 01=64 Hz, 10=1 Hz, 11=1/60 Hz; reset 11.
// - Timer control bit 3 runs the countdown when one.
// - Eight-bit binary down counter; zero stops it, 1 to 255 valid.
// - On a tick with the counter at one, set countdown flag and reload the programmed value.
// - Reading the countdown register returns the live counter.
// - A new reload value takes effect at once.
// - No tick when both enables zero; minute alone per minute; else per second.
// - Tick flag sets on second increment, or minute increment if only minutes.
// - Tick interrupt pulses occur whatever the tick flag state.
// - Tick and slow countdown periods follow correction applied to the ticks.
// - A countdown period is reload value over source frequency.
// - Countdown flag drives interrupt only if enabled; pulse or level selectable.
// - Interrupt is active low, open drain, wired-OR of all sources.
// - Tick pulse lasts one 64 Hz period; clearing the flag shortens it.
module rta_timer (
  input wire core_clk,
  input wire rst,
  input wire spi_sclk,
  input wire spi_ce,
  input wire spi_sdi,
  output reg spi_sdo,
  output reg spi_sdo_oe,
  input wire [7:0] cur_minute,
  input wire [7:0] cur_hour,
  input wire [7:0] cur_day,
  input wire [7:0] cur_weekday,
  input wire second_inc,
  input wire minute_inc,
  input wire tick_4096hz,
  input wire tick_64hz,
  input wire tick_1hz,
  input wire tick_1_60hz,
  input wire corr_irq,
  output reg irq_n_out,
  output reg irq_n_oe,
  output reg [2:0] clock_out_select
);

  // =============================================================
  // Pin synchronisers
  // Each serial pin passes two flip-flops before any logic reads it. The serial
  // clock has a third stage so that its edges are found without touching
  // a possibly metastable flop. Each half period of the serial clock must
  // last at least four core cycles, or an edge can be missed.
  reg [2:0] sclk_s_q;
  reg [1:0] ce_s_q;
  reg [1:0] sdi_s_q;

  always @(posedge core_clk) begin
    if (rst) begin
      sclk_s_q <= 3'h0;
      ce_s_q <= 2'h0;
      sdi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
      ce_s_q <= {ce_s_q[0], spi_ce};
      sdi_s_q <= {sdi_s_q[0], spi_sdi};
    end
  end

  wire ce = ce_s_q[1];
  wire sdi = sdi_s_q[1];
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];

  // =============================================================
  // Register state
  // The interrupt control byte holds the enables and all three flags.
  reg [7:0] alm_min_q;
  reg [7:0] alm_hour_q;
  reg [7:0] alm_day_q;
  reg [7:0] alm_wday_q;
  reg [7:0] ictl_q;
  reg [7:0] tctl_q;
  reg [7:0] reload_q;
  reg [7:0] count_q;

  wire minute_en = ictl_q[`RTA_IC_MINUTE_EN];
  wire second_en = ictl_q[`RTA_IC_SECOND_EN];
  wire tick_flag = ictl_q[`RTA_IC_TICK_FLAG];
  wire irq_pulse_select = ictl_q[`RTA_IC_PULSE_SEL];
  wire alarm_hit_flag = ictl_q[`RTA_IC_ALARM_FLAG];
  wire countdown_flag = ictl_q[`RTA_IC_CD_FLAG];
  wire alarm_irq_enable = ictl_q[`RTA_IC_ALARM_IE];
  wire countdown_irq_enable = ictl_q[`RTA_IC_CD_IE];
  wire countdown_run = tctl_q[`RTA_TC_RUN];
  wire [1:0] countdown_clock_select = tctl_q[`RTA_TC_SEL_HI:`RTA_TC_SEL_LO];

  // =============================================================
  // Serial slave: command byte, then data bytes with address increment
  // A frame opens with chip enable high. The first byte is the command:
  // bit 7 selects a read, bits 6:4 must hold the subaddress and bits 3:0
  // the register. Every later byte is data, with the address counting up.
  // A frame with a wrong subaddress is ignored as a whole, and dropping
  // chip enable abandons a partial byte.
  reg [2:0] bit_cnt_q;
  reg [7:0] rx_q;
  reg [7:0] tx_q;
  reg cmd_done_q;
  reg rd_mode_q;
  reg sub_ok_q;
  reg [3:0] addr_q;
  reg [7:0] rdata;

  wire [7:0] rx_byte = {rx_q[6:0], sdi};
  wire byte_done = ce & sclk_rise & (bit_cnt_q == 3'h7);
  wire wr_byte = byte_done & cmd_done_q & ~rd_mode_q & sub_ok_q;
  wire [3:0] cmd_addr = rx_byte[3:0];
  wire [3:0] next_addr = cmd_done_q ? addr_q + 4'h1 : cmd_addr;
  wire next_rd = cmd_done_q ? rd_mode_q : rx_byte[`RTA_CMD_READ_BIT];
  wire next_ok = cmd_done_q ? sub_ok_q :
    (rx_byte[`RTA_CMD_SUB_HI:`RTA_CMD_SUB_LO] == `RTA_CMD_SUBADDR);

  always @* begin
    case (next_addr)
      `RTA_ADDR_IRQ_CTRL: rdata = ictl_q;
      `RTA_ADDR_ALM_MIN: rdata = alm_min_q;
      `RTA_ADDR_ALM_HOUR: rdata = alm_hour_q;
      `RTA_ADDR_ALM_DAY: rdata = alm_day_q;
      `RTA_ADDR_ALM_WDAY: rdata = alm_wday_q;
      `RTA_ADDR_TMR_CTRL: rdata = tctl_q;
      `RTA_ADDR_CD_RELOAD: rdata = count_q;
      default: rdata = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst || !ce) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_done_q <= 1'b0;
      rd_mode_q <= 1'b0;
      sub_ok_q <= 1'b0;
      addr_q <= 4'h0;
      spi_sdo <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        rx_q <= rx_byte;
      end
      if (byte_done) begin
        cmd_done_q <= 1'b1;
        rd_mode_q <= next_rd;
        sub_ok_q <= next_ok;
        addr_q <= next_addr;
        if (next_rd && next_ok) begin
          tx_q <= rdata;
          spi_sdo <= rdata[7];
          spi_sdo_oe <= 1'b1;
        end
      end else if (sclk_fall && spi_sdo_oe) begin
        // The first falling edge after a load presents bit 7 again, so the
        // host sees every bit through a whole high phase of its clock.
        spi_sdo <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // =============================================================
  // Write strobes
  // A data byte is written to the address held in addr_q: the command
  // byte's address for the first data byte, one more for each after.
  // next_addr runs one byte ahead because it feeds the read prefetch.
  wire [3:0] wr_addr = addr_q;
  wire wr_alm_min = wr_byte & (wr_addr == `RTA_ADDR_ALM_MIN);
  wire wr_alm_hour = wr_byte & (wr_addr == `RTA_ADDR_ALM_HOUR);
  wire wr_alm_day = wr_byte & (wr_addr == `RTA_ADDR_ALM_DAY);
  wire wr_alm_wday = wr_byte & (wr_addr == `RTA_ADDR_ALM_WDAY);
  wire wr_ictl = wr_byte & (wr_addr == `RTA_ADDR_IRQ_CTRL);
  wire wr_tctl = wr_byte & (wr_addr == `RTA_ADDR_TMR_CTRL);
  wire wr_reload = wr_byte & (wr_addr == `RTA_ADDR_CD_RELOAD);

  // =============================================================
  // Alarm comparison
  // Each field compares only its masked BCD bits, so unused bits in an
  // alarm register never block a match.
  wire min_hit = alm_min_q[`RTA_ALM_DIS_BIT] |
    (((alm_min_q ^ cur_minute) & `RTA_ALM_MIN_MASK) == 8'h00);
  wire hour_hit = alm_hour_q[`RTA_ALM_DIS_BIT] |
    (((alm_hour_q ^ cur_hour) & `RTA_ALM_HOUR_MASK) == 8'h00);
  wire day_hit = alm_day_q[`RTA_ALM_DIS_BIT] |
    (((alm_day_q ^ cur_day) & `RTA_ALM_DAY_MASK) == 8'h00);
  wire wday_hit = alm_wday_q[`RTA_ALM_DIS_BIT] |
    (((alm_wday_q ^ cur_weekday) & `RTA_ALM_WDAY_MASK) == 8'h00);
  // With every field disabled nothing is compared, so no alarm at all.
  wire any_alm_en = ~(alm_min_q[7] & alm_hour_q[7] & alm_day_q[7] &
    alm_wday_q[7]);
  wire alarm_match = any_alm_en & min_hit & hour_hit & day_hit & wday_hit;
  reg alarm_match_q;
  // Only a new entry into the matching state sets the flag.
  wire alarm_set = alarm_match & ~alarm_match_q;

  // =============================================================
  // Periodic tick and countdown events
  wire tick_set = second_en ? second_inc : (minute_en & minute_inc);

  // The slow taps arrive already corrected, so 1 Hz and 1/60 Hz periods
  // may vary by a correction step; the fast taps never do.
  reg src_tick;
  always @* begin
    case (countdown_clock_select)
      `RTA_SEL_4096HZ: src_tick = tick_4096hz;
      `RTA_SEL_64HZ: src_tick = tick_64hz;
      `RTA_SEL_1HZ: src_tick = tick_1hz;
      `RTA_SEL_1_60HZ: src_tick = tick_1_60hz;
      default: src_tick = 1'b0;
    endcase
  end

  // The counter moves only on a tick of the chosen source while the timer
  // runs; a count of zero parks it until a new value is written.
  wire cd_step = countdown_run & src_tick & (count_q != 8'h00);
  wire cd_set = cd_step & (count_q == 8'h01);

  // Slow sources time their pulse on 64 Hz, fast ones on the next source edge.
  wire cd_pulse_end = countdown_clock_select[1] ? tick_64hz : src_tick;

  // =============================================================
  // Register writes, flags and counter
  always @(posedge core_clk) begin
    if (rst) begin
      alm_min_q <= `RTA_RST_ALARM;
      alm_hour_q <= `RTA_RST_ALARM;
      alm_day_q <= `RTA_RST_ALARM;
      alm_wday_q <= `RTA_RST_ALARM;
      ictl_q <= `RTA_RST_IRQ_CTRL;
      tctl_q <= `RTA_RST_TMR_CTRL;
      reload_q <= `RTA_RST_RELOAD;
      count_q <= `RTA_RST_RELOAD;
      alarm_match_q <= 1'b0;
    end else begin
      alarm_match_q <= alarm_match;
      // Alarm registers keep all eight bits, so unused bits read back as
      // written while the compare masks ignore them.
      if (wr_alm_min) begin
        alm_min_q <= rx_byte;
      end
      if (wr_alm_hour) begin
        alm_hour_q <= rx_byte;
      end
      if (wr_alm_day) begin
        alm_day_q <= rx_byte;
      end
      if (wr_alm_wday) begin
        alm_wday_q <= rx_byte;
      end
      // Bits 7 and 2 of the timer control are unused and read as zero.
      if (wr_tctl) begin
        tctl_q <= rx_byte & `RTA_TMR_CTRL_MASK;
      end
      if (wr_ictl) begin
        ictl_q[`RTA_IC_MINUTE_EN] <= rx_byte[`RTA_IC_MINUTE_EN];
        ictl_q[`RTA_IC_SECOND_EN] <= rx_byte[`RTA_IC_SECOND_EN];
        ictl_q[`RTA_IC_PULSE_SEL] <= rx_byte[`RTA_IC_PULSE_SEL];
        ictl_q[`RTA_IC_ALARM_IE] <= rx_byte[`RTA_IC_ALARM_IE];
        ictl_q[`RTA_IC_CD_IE] <= rx_byte[`RTA_IC_CD_IE];
      end
      // Flags are AND-on-write: a zero clears, a one keeps, so the host
      // writes ones to every flag that it does not mean to clear.
      // A flag set in the same cycle as a clearing write stays set.
      ictl_q[`RTA_IC_TICK_FLAG] <= tick_set |
        (tick_flag & (~wr_ictl | rx_byte[`RTA_IC_TICK_FLAG]));
      ictl_q[`RTA_IC_ALARM_FLAG] <= alarm_set |
        (alarm_hit_flag & (~wr_ictl | rx_byte[`RTA_IC_ALARM_FLAG]));
      ictl_q[`RTA_IC_CD_FLAG] <= cd_set |
        (countdown_flag & (~wr_ictl | rx_byte[`RTA_IC_CD_FLAG]));
      // A written value replaces the running count at once; if the
      // timer is still running this first period may be off by a tick.
      if (wr_reload) begin
        reload_q <= rx_byte;
        count_q <= rx_byte;
      end else if (cd_set) begin
        count_q <= reload_q;
      end else if (cd_step) begin
        count_q <= count_q - 8'h01;
      end
    end
  end

  // =============================================================
  // Interrupt pulse generators and open-drain output
  // The pin is open drain: its data level is always low and the enable
  // carries the interrupt, so a high enable pulls the line low.
  // Registering the enable costs one cycle of latency but keeps the pad
  // free of glitches from the combinational OR of the sources.
  reg tick_pulse_q;
  reg cd_pulse_q;

  always @(posedge core_clk) begin
    if (rst) begin
      tick_pulse_q <= 1'b0;
      cd_pulse_q <= 1'b0;
    end else begin
      if (tick_set)
        tick_pulse_q <= 1'b1;
      else if (tick_64hz || !tick_flag)
        tick_pulse_q <= 1'b0;
      if (cd_set)
        cd_pulse_q <= 1'b1;
      else if (cd_pulse_end || !countdown_flag)
        cd_pulse_q <= 1'b0;
    end
  end

  wire tick_src = irq_pulse_select ? tick_pulse_q : tick_flag;
  wire cd_src = countdown_irq_enable &
    (irq_pulse_select ? cd_pulse_q : countdown_flag);
  wire alm_src = alarm_irq_enable & alarm_hit_flag;
  wire irq_any = tick_src | cd_src | alm_src | corr_irq;

  always @(posedge core_clk) begin
    if (rst) begin
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b0;
      clock_out_select <= 3'h0;
    end else begin
      irq_n_out <= 1'b0;
      irq_n_oe <= irq_any;
      clock_out_select <= tctl_q[`RTA_TC_COF_HI:`RTA_TC_COF_LO];
    end
  end

endmodule // rta_timer

// >>> rta_timer_checker.sv
// Concurrent checks on the timer block's pins, bound into the design.
module rta_timer_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_ce,
  input wire logic spi_sdo_oe,
  input wire logic [7:0] cur_minute,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_day,
  input wire logic [7:0] cur_weekday,
  input wire logic second_inc,
  input wire logic minute_inc,
  input wire logic tick_4096hz,
  input wire logic tick_64hz,
  input wire logic tick_1hz,
  input wire logic tick_1_60hz,
  input wire logic corr_irq,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [2:0] clock_out_select
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Activity tracker
  // An interrupt change must follow some input activity; a stuck or
  // spontaneous interrupt shows up as a change in a quiet stretch.
  logic [31:0] cur_q;
  logic [3:0] quiet_q;
  logic act;
  assign act = spi_ce | corr_irq | second_inc | minute_inc | tick_4096hz
    | tick_64hz | tick_1hz | tick_1_60hz
    | (cur_q != {cur_minute, cur_hour, cur_day, cur_weekday});
  always_ff @(posedge core_clk) begin
    cur_q <= {cur_minute, cur_hour, cur_day, cur_weekday};
    if (rst || act) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_irq_pin_low: assert property (irq_n_out == 1'b0)
    else $error("interrupt data level not low");
  a_corr_to_irq: assert property (corr_irq |=> irq_n_oe)
    else $error("correction source did not pull interrupt");
  a_irq_rise_cause: assert property ($rose(irq_n_oe) |-> quiet_q < 4'h6)
    else $error("interrupt rose without a cause");
  a_irq_fall_cause: assert property ($fell(irq_n_oe) |-> quiet_q < 4'h6)
    else $error("interrupt fell without a cause");
  a_sdo_release: assert property ($fell(spi_ce) |-> ##[1:5] !spi_sdo_oe)
    else $error("data out not released after frame");
  a_sdo_start: assert property ($rose(spi_sdo_oe) |-> spi_ce && spi_sclk)
    else $error("data out enabled outside a read byte");
  a_cos_by_write: assert property ($changed(clock_out_select) |-> spi_ce)
    else $error("clock out select moved without a write");
  a_reset_state: assert property ($fell(rst) |-> clock_out_select == 3'h0
    && !irq_n_oe)
    else $error("outputs not cleared by reset");
  c_irq_raised: cover property ($rose(irq_n_oe));
  c_read_out: cover property ($rose(spi_sdo_oe));
  c_cos_set: cover property ($changed(clock_out_select));
endmodule // rta_timer_checker

bind rta_timer rta_timer_checker u_rta_timer_checker (.core_clk(core_clk),
  .rst(rst), .spi_sclk(spi_sclk), .spi_ce(spi_ce), .spi_sdo_oe(spi_sdo_oe),
  .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_day(cur_day),
  .cur_weekday(cur_weekday), .second_inc(second_inc),
  .minute_inc(minute_inc), .tick_4096hz(tick_4096hz),
  .tick_64hz(tick_64hz), .tick_1hz(tick_1hz), .tick_1_60hz(tick_1_60hz),
  .corr_irq(corr_irq), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
  .clock_out_select(clock_out_select));

// >>> rta_host_model.sv
// Host-side serial master model that drives the timer's register port.
`include "rta_defines.vh"
module rta_host_model (
  input wire logic core_clk,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_ce,
  output logic spi_sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_ce = 1'b0;
    spi_sdi = 1'b0;
  end
  // Six core cycles per half period leaves margin over the synchroniser.
  task automatic half();
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  // One command byte and one data byte; read data is taken at rising edges.
  task automatic frame(input logic rd, input logic [2:0] sa,
    input logic [3:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {rd, sa, a, wd};
    rdat = 8'h00;
    @(posedge core_clk);
    #1;
    spi_ce = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = sh[i];
      half();
      spi_sclk = 1'b1;
      if (i < 8) rdat[i] = spi_sdo;
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_ce = 1'b0;
    // The idle data line must not keep looking like the last bit.
    spi_sdi = ~spi_sdi;
    half();
  endtask
endmodule // rta_host_model

// >>> rta_timer_tb.sv
// Self-checking bench for the alarm, tick and countdown block.
`include "rta_defines.vh"
module rta_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic corr_irq = 1'b0;
  logic [5:0] ev = 6'h00;
  logic [7:0] cm = 8'h30;
  logic spi_sclk, spi_ce, spi_sdi, spi_sdo, spi_sdo_oe, irq_n_out, irq_n_oe;
  // A released data line shows the inverse of the last bit, so a read
  // only passes while the design really drives the line.
  logic sdo_line;
  assign sdo_line = spi_sdo_oe ? spi_sdo : ~spi_sdo;
  logic [2:0] clock_out_select;
  logic [7:0] d, e;
  int n_checks = 0;
  int n_mismatch = 0;
  always #4 core_clk = ~core_clk;
  rta_timer u_rta_timer (.core_clk(core_clk), .rst(rst),
    .spi_sclk(spi_sclk), .spi_ce(spi_ce), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .cur_minute(cm),
    .cur_hour(8'h12), .cur_day(8'h05), .cur_weekday(8'h03),
    .second_inc(ev[4]), .minute_inc(ev[5]), .tick_4096hz(ev[0]),
    .tick_64hz(ev[1]), .tick_1hz(ev[2]), .tick_1_60hz(ev[3]),
    .corr_irq(corr_irq), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
    .clock_out_select(clock_out_select));
  rta_host_model u_rta_host_model (.core_clk(core_clk), .spi_sdo(sdo_line),
    .spi_sclk(spi_sclk), .spi_ce(spi_ce), .spi_sdi(spi_sdi));
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] x,
    input logic [7:0] g);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    u_rta_host_model.frame(1'b0, `RTA_CMD_SUBADDR, a, v, d);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] x);
    u_rta_host_model.frame(1'b1, `RTA_CMD_SUBADDR, a, 8'h00, d);
    chk($sformatf("reg %h", a), x, d);
  endtask
  task automatic pulse(input logic [5:0] m);
    @(posedge core_clk);
    #1;
    ev = m;
    @(posedge core_clk);
    #1;
    ev = 6'h00;
  endtask
  task automatic ck_irq(input logic x);
    repeat (3) @(posedge core_clk);
    #1;
    chk("irq", {7'h00, x}, {7'h00, irq_n_oe});
  endtask
  // ==========================================================
  // Tests
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge core_clk);
    rc(`RTA_ADDR_TMR_CTRL, 8'h03);
    rc(`RTA_ADDR_IRQ_CTRL, 8'h00);
    rc(`RTA_ADDR_CD_RELOAD, 8'h00);
    for (int a = 9; a <= 12; a++) rc(a[3:0], 8'h80);
    rc(4'hD, 8'h00);
    wr(`RTA_ADDR_TMR_CTRL, 8'hFF);
    rc(`RTA_ADDR_TMR_CTRL, 8'h7B);
    chk("clkout", 8'h07, {5'h00, clock_out_select});
    u_rta_host_model.frame(1'b0, 3'h2, 4'hF, 8'hAA, d);
    rc(`RTA_ADDR_CD_RELOAD, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(4'hE, s[7:0]);
      wr(4'hF, 8'h02);
      wr(4'hE, 8'h08 | s[7:0]);
      pulse(6'h0F & ~(6'h01 << s));
      rc(4'hF, 8'h02);
      pulse(6'h01 << s);
      rc(4'hF, 8'h01);
    end
    pulse(6'h08);
    rc(4'hF, 8'h02);
    rc(4'h1, 8'h04);
    wr(4'hF, 8'h05);
    rc(4'hF, 8'h05);
    wr(4'hE, 8'h03);
    pulse(6'h08);
    rc(4'hF, 8'h05);
    wr(4'h1, 8'h05);
    ck_irq(1'b1);
    wr(4'h1, 8'h01);
    ck_irq(1'b0);
    wr(4'hF, 8'h00);
    wr(4'hE, 8'h0B);
    pulse(6'h08);
    rc(4'hF, 8'h00);
    rc(4'h1, 8'h01);
    wr(4'hE, 8'h03);
    $display("test countdown done");
    for (int m = 0; m < 4; m++) begin
      e = {m[1:0], 6'h00};
      wr(4'h1, e);
      pulse(6'h10);
      rc(4'h1, e | {2'h0, m[0], 5'h00});
      wr(4'h1, e);
      pulse(6'h20);
      rc(4'h1, e | {2'h0, m[1] & ~m[0], 5'h00});
      wr(4'h1, e);
    end
    wr(4'h1, 8'h40);
    pulse(6'h10);
    wr(4'hF, 8'h01);
    wr(4'hE, 8'h0A);
    pulse(6'h04);
    rc(4'h1, 8'h64);
    wr(4'h1, 8'h68);
    rc(4'h1, 8'h60);
    wr(4'hE, 8'h03);
    wr(4'h1, 8'h50);
    repeat (2) begin
      pulse(6'h10);
      ck_irq(1'b1);
      pulse(6'h02);
      ck_irq(1'b0);
    end
    wr(4'h1, 8'h11);
    wr(4'hE, 8'h0A);
    pulse(6'h04);
    ck_irq(1'b1);
    pulse(6'h02);
    ck_irq(1'b0);
    rc(4'h1, 8'h15);
    wr(4'hE, 8'h03);
    wr(4'h1, 8'h00);
    $display("test ticks done");
    wr(`RTA_ADDR_ALM_HOUR, 8'h91);
    wr(`RTA_ADDR_ALM_MIN, 8'h30);
    rc(4'h1, 8'h08);
    wr(4'h1, 8'h0A);
    ck_irq(1'b1);
    wr(4'h1, 8'h02);
    rc(4'h1, 8'h02);
    cm = 8'h31;
    rc(4'h1, 8'h02);
    cm = 8'h30;
    rc(4'h1, 8'h0A);
    cm = 8'h31;
    rc(4'h1, 8'h0A);
    wr(4'h1, 8'h00);
    ck_irq(1'b0);
    $display("test alarm done");
    corr_irq = 1'b1;
    ck_irq(1'b1);
    corr_irq = 1'b0;
    ck_irq(1'b0);
    $display("test interrupt done");
    give_verdict();
  end
endmodule // rta_timer_tb
